/* hw/flea_pkg.sv */
// Purpose: Shared constants for the fault log and user storage access block
// Assumes: 40 MHz mclk, synchronous active-low reset
// Notes: Command codes are the management command bytes seen on the port
// Summary of operation
// [R01] Oldest record spans log bytes 127 to 146
// [R02] Records tagged with fault source code byte
// [R03] Log erase command wipes all log bytes
// [R04] Log erase also clears vendor status bit 3
// [R05] Status bit cleared within 8 ms of erase
// [R06] Host sends log erase as data-less send-byte
// [R07] Unlock command enables erase and data access
// [R08] Bulk erase command prepares storage for programming
// [R09] Data command moves sequential 16-bit words, unpaged
// [R10] Storage commands blocked above 130 C die temp
// [R11] Storage commands re-enabled below 125 C die temp
// [R12] Word pointer advances after each data access
package flea_pkg;
  localparam logic [7:0] CMD_LOG_ERASE = 8'hee;   // Command byte of the log erase
  localparam logic [7:0] CMD_EE_UNLOCK = 8'hbd;
  localparam logic [7:0] CMD_EE_ERASE = 8'hbe;
  localparam logic [7:0] CMD_EE_DATA = 8'hbf;
  localparam logic [7:0] UNLOCK_KEY = 8'h2b;      // Value that unlocks; arbitrary
  localparam int LOG_BYTES = 147;                 // Log bytes 0..146
  localparam logic [7:0] OLDEST_FIRST = 8'h7f;    // Byte 127
  localparam logic [7:0] OLDEST_LAST = 8'h92;     // Byte 146
  localparam logic [7:0] SRC_MANUAL = 8'hff;
  localparam logic [7:0] SRC_CH1_OFS = 8'h10;
  localparam int VSTAT_LOG_BIT = 3;
  localparam int EE_WORDS = 64;
  localparam int EE_AW = 6;
  localparam logic [15:0] EE_BLANK = 16'hffff;
  localparam logic [7:0] TEMP_HOT = 8'd130;       // Degrees C, disable above
  localparam logic [7:0] TEMP_COOL = 8'd125;      // Degrees C, enable below
  localparam int CLK_HZ = 40000000;
  localparam int STAT_CLR_MS = 8;
  localparam int STAT_CLR_CYC = (CLK_HZ / 1000) * STAT_CLR_MS;
  localparam int FIFO_W = 16;
  localparam int FIFO_D = 16;
endpackage

/* hw/flea_fifo.sv */
// Purpose: Small valid/ready FIFO for words written to the data command
// Assumes: One clock, synchronous active-low reset
// Notes: Depth must be a power of two
`timescale 1ns/100ps
module flea_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input wire logic mclk, // Clock
  input wire logic rst_b, // Sync reset, low
  input wire logic in_valid, // Write request
  output logic in_ready, // Not full
  input wire logic [W-1:0] in_data, // Write word
  output logic out_valid, // Not empty
  input wire logic out_ready, // Drain accepts
  output logic [W-1:0] out_data // Head word
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D]; // Storage
  logic [AW:0] wp; // Write pointer with wrap bit
  logic [AW:0] rp; // Read pointer with wrap bit
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (wp[AW-1:0] != rp[AW-1:0]) || (wp[AW] == rp[AW]);
  assign out_valid = (wp != rp);
  assign out_data = mem[rp[AW-1:0]];
  // Pointer update
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
    end
  end
  // Storage write, no reset needed
  always_ff @(posedge mclk) begin
    if (push) mem[wp[AW-1:0]] <= in_data;
  end
endmodule // flea_fifo

/* hw/flea_top.sv */
// Purpose: Fault log store and user storage command handling
// Assumes: Command port decoded upstream; temperature in whole degrees C
// Notes: Storage is flip-flops; programming drains through a FIFO
`timescale 1ns/100ps
module flea_top #(
  parameter int STAT_CLR_CYC = flea_pkg::STAT_CLR_CYC // Status clear delay
) (
  input wire logic mclk, // 40 MHz clock
  input wire logic rst_b, // Sync reset, low
  input wire logic cmd_wr, // Command write strobe
  input wire logic cmd_rd, // Command read strobe
  input wire logic [7:0] cmd_code, // Command byte
  input wire logic [15:0] cmd_wdata, // Write data
  output logic [15:0] cmd_rdata, // Read data
  output logic cmd_ack, // Accepted pulse
  output logic cmd_nack, // Refused pulse
  input wire logic [7:0] die_temp, // Die temperature pin, async
  input wire logic log_wr, // Log byte write from capture
  input wire logic [7:0] log_addr, // Log byte index
  input wire logic [7:0] log_wdata, // Log byte data
  input wire logic [7:0] log_raddr, // Log read index
  output logic [7:0] log_rdata, // Log byte read
  input wire logic fault_ev, // Fault capture event
  input wire logic fault_ch, // Channel of fault
  input wire logic [3:0] fault_kind, // Fault kind code
  input wire logic manual_save, // Manual store event
  output logic [7:0] src_code, // Last source code
  output logic [1:0] vstat_bit3, // Vendor status bit 3 per channel
  output logic ee_enabled // Storage commands allowed
);
  // Synchronised temperature
  logic [7:0] temp_s1;
  logic [7:0] temp_s2;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      temp_s1 <= '0;
      temp_s2 <= '0;
    end else begin
      temp_s1 <= die_temp;
      temp_s2 <= temp_s1;
    end
  end

  // Hot lockout with hysteresis
  logic hot;
  wire next_hot = hot ? (temp_s2 >= flea_pkg::TEMP_COOL) // see [R11]
                      : (temp_s2 > flea_pkg::TEMP_HOT); // see [R10]
  always_ff @(posedge mclk) begin
    if (!rst_b) hot <= 1'b0;
    else hot <= next_hot;
  end

  // Command decode
  wire is_log_clr = cmd_wr && (cmd_code == flea_pkg::CMD_LOG_ERASE); // see [R06]
  wire is_unlock = (cmd_code == flea_pkg::CMD_EE_UNLOCK);
  wire is_erase = (cmd_code == flea_pkg::CMD_EE_ERASE);
  wire is_data = (cmd_code == flea_pkg::CMD_EE_DATA); // Unpaged, see [R09]
  wire ee_cmd = (cmd_wr || cmd_rd) && (is_unlock || is_erase || is_data);
  logic unlocked;
  wire ee_ok = !hot; // see [R10]
  wire need_unlk = is_erase || is_data;
  wire ee_refuse = ee_cmd && (!ee_ok || (need_unlk && !unlocked)); // see [R07]
  wire log_rd_bad = cmd_rd && (cmd_code == flea_pkg::CMD_LOG_ERASE); // see [R06]
  wire ee_go = ee_cmd && !ee_refuse;

  // Unlock state
  always_ff @(posedge mclk) begin
    if (!rst_b) unlocked <= 1'b0;
    else if (ee_go && is_unlock && cmd_wr)
      unlocked <= (cmd_wdata[7:0] == flea_pkg::UNLOCK_KEY); // see [R07]
  end

  // Storage array and pointer
  typedef enum logic [1:0] {FLEA_IDLE, FLEA_ERASE} flea_state_e;
  flea_state_e st;
  logic [flea_pkg::EE_AW-1:0] eptr; // Erase sweep index
  logic [flea_pkg::EE_AW-1:0] wptr; // Word pointer
  logic [15:0] ee_mem [flea_pkg::EE_WORDS];
  logic f_valid;
  logic [15:0] f_data;
  wire f_ready = (st == FLEA_IDLE);
  logic f_in_ready;
  wire data_wr = ee_go && is_data && cmd_wr;
  wire data_rd = ee_go && is_data && cmd_rd;
  wire erase_go = ee_go && is_erase && cmd_wr;

  flea_fifo #(.W(flea_pkg::FIFO_W), .D(flea_pkg::FIFO_D)) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .in_valid(data_wr),
    .in_ready(f_in_ready),
    .in_data(cmd_wdata),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // Erase sweep and programming
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st <= FLEA_IDLE;
      eptr <= '0;
      wptr <= '0;
    end else begin
      unique case (st)
        FLEA_IDLE: begin
          if (erase_go) begin
            st <= FLEA_ERASE; // see [R08]
            eptr <= '0;
          end else if (f_valid || data_rd) begin
            wptr <= wptr + 1'b1; // see [R12]
          end
        end
        FLEA_ERASE: begin
          eptr <= eptr + 1'b1;
          if (eptr == flea_pkg::EE_AW'(flea_pkg::EE_WORDS - 1)) begin
            st <= FLEA_IDLE;
            wptr <= '0; // see [R12]
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (st == FLEA_ERASE) ee_mem[eptr] <= flea_pkg::EE_BLANK; // see [R08]
    else if (f_valid) ee_mem[wptr] <= f_data; // see [R09]
  end

  // Answers: busy erase or full FIFO also refused
  wire busy = (st != FLEA_IDLE) && is_data;
  wire full_ref = data_wr && !f_in_ready;
  wire rd_wait = data_rd && f_valid;
  wire nack_now = ee_refuse || log_rd_bad || ((busy || full_ref || rd_wait) && ee_cmd);
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cmd_ack <= 1'b0;
      cmd_nack <= 1'b0;
      cmd_rdata <= '0;
    end else begin
      cmd_ack <= (ee_cmd || is_log_clr) && !nack_now;
      cmd_nack <= nack_now;
      if (data_rd && !nack_now) cmd_rdata <= ee_mem[wptr]; // see [R09]
      else if (ee_go && cmd_rd && is_unlock) cmd_rdata <= {15'h0000, unlocked}; // Refused reads keep old data
    end
  end

  // Fault log bytes
  logic [7:0] log_mem [flea_pkg::LOG_BYTES];
  logic [7:0] clr_idx;
  logic clr_run;
  wire clr_last = (clr_idx == flea_pkg::OLDEST_LAST); // Last byte of oldest, see [R01]
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      clr_run <= 1'b0;
      clr_idx <= '0;
    end else if (is_log_clr) begin
      clr_run <= 1'b1; // see [R03]
      clr_idx <= '0;
    end else if (clr_run) begin
      clr_idx <= clr_idx + 1'b1;
      if (clr_last) clr_run <= 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (clr_run) log_mem[clr_idx] <= 8'h00; // see [R03]
    else if (log_wr && log_addr <= flea_pkg::OLDEST_LAST) log_mem[log_addr] <= log_wdata; // see [R01]
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) log_rdata <= '0;
    else if (log_raddr <= flea_pkg::OLDEST_LAST) log_rdata <= log_mem[log_raddr];
    else log_rdata <= '0;
  end

  // Source code tag
  always_ff @(posedge mclk) begin
    if (!rst_b) src_code <= '0;
    else if (manual_save) src_code <= flea_pkg::SRC_MANUAL; // see [R02]
    else if (fault_ev)
      src_code <= {4'h0, fault_kind} | (fault_ch ? flea_pkg::SRC_CH1_OFS : 8'h00); // see [R02]
  end

  // Vendor status bit 3, cleared after delay; new event wins
  logic [31:0] sdly;
  logic spend;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      spend <= 1'b0;
      sdly <= '0;
      vstat_bit3 <= '0;
    end else begin
      if (is_log_clr) begin
        spend <= 1'b1;
        sdly <= 32'(STAT_CLR_CYC - 1);
      end else if (spend && sdly != 0) sdly <= sdly - 1'b1;
      else spend <= 1'b0;
      if (fault_ev || manual_save) vstat_bit3 <= 2'b11;
      else if (spend && sdly == 0) vstat_bit3 <= 2'b00; // see [R04] [R05]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) ee_enabled <= 1'b0;
    else ee_enabled <= !next_hot;
  end
endmodule // flea_top

/* verification/flea_chk.sv */
// Purpose: Port checker for the fault log and storage block
// Assumes: Single mclk domain, rst_b synchronous and low active
// Notes: Temperature path latency taken as at most four cycles
`timescale 1ns/100ps
module flea_chk #(
  parameter int STAT_CLR_CYC = 16 // Status clear delay
) (
  input wire logic mclk, // Clock
  input wire logic rst_b, // Reset, low
  input wire logic cmd_wr, // Write strobe
  input wire logic cmd_rd, // Read strobe
  input wire logic [7:0] cmd_code, // Command
  input wire logic cmd_ack, // Accepted
  input wire logic cmd_nack, // Refused
  input wire logic [7:0] die_temp, // Temperature
  input wire logic fault_ev, // Fault event
  input wire logic fault_ch, // Fault channel
  input wire logic [3:0] fault_kind, // Fault kind
  input wire logic manual_save, // Manual store
  input wire logic [7:0] src_code, // Source code
  input wire logic [1:0] vstat_bit3, // Status bits
  input wire logic ee_enabled // Storage allowed
);
  localparam int CLR_MAX = STAT_CLR_CYC + 2; // Slack for the ack cycle
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Storage codes form one contiguous block
  wire ee_cmd = cmd_code >= 8'hbd && cmd_code <= 8'hbf;
  chk_one_answer: assert property ((cmd_wr || cmd_rd) |=> cmd_ack != cmd_nack)
    else $error("request without exactly one answer");
  chk_erase_noread: assert property (cmd_rd && cmd_code == 8'hee |=> cmd_nack)
    else $error("log erase read not refused");
  chk_hot_refuse: assert property (!ee_enabled && cmd_wr && ee_cmd |=> cmd_nack)
    else $error("storage command taken while hot");
  chk_hot_blocks: assert property ((die_temp > 8'd130) [*5] |-> !ee_enabled)
    else $error("storage still allowed while hot");
  // Warm but not cool must never re-enable
  chk_warm_holds:
  assert property ((die_temp >= 8'd125) [*5] |-> $past(ee_enabled) || !ee_enabled)
    else $error("storage re-enabled above lower threshold");
  chk_cool_enables: assert property ((die_temp < 8'd125) [*5] |-> ee_enabled)
    else $error("storage not re-enabled when cool");
  chk_fault_source:
  assert property (fault_ev && !manual_save |=>
    src_code == {3'b000, $past(fault_ch), $past(fault_kind)}) else $error("wrong source code");
  // A fresh event may legally set the bit again
  chk_status_clear:
  assert property (cmd_wr && cmd_code == 8'hee ##1 cmd_ack |-> ##[0:CLR_MAX]
    (vstat_bit3 == 2'b00 || fault_ev || manual_save)) else $error("status bit not cleared");
  cov_refused: cover property (cmd_wr && ee_cmd ##1 cmd_nack);
  cov_hot: cover property ($fell(ee_enabled));
  cov_cleared: cover property ($fell(vstat_bit3[1]));
endmodule // flea_chk
bind flea_top flea_chk #(.STAT_CLR_CYC(STAT_CLR_CYC)) flea_chk_i (.*);

/* verification/flea_host.sv */
// Purpose: Management host model driving the command port
// Assumes: Commands launched on the falling edge of mclk
// Notes: Caller reads the answer when the task returns
`timescale 1ns/100ps
module flea_host (
  input wire logic mclk, // Clock
  output logic cmd_wr, // Write strobe
  output logic cmd_rd, // Read strobe
  output logic [7:0] cmd_code, // Command
  output logic [15:0] cmd_wdata // Word
);
  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // One strobe cycle per transfer, a whole 16-bit word each
  task automatic xfer(input logic rd, input logic [7:0] code, input logic [15:0] wd);
    @(negedge mclk);
    cmd_rd = rd;
    cmd_wr = !rd;
    cmd_code = code;
    // Log erase is a bare send-byte, so the word lines carry junk
    cmd_wdata = (code == 8'hee) ? ~cmd_wdata : wd;
    @(negedge mclk);
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    // Released word lines must not keep the last value
    cmd_wdata = ~cmd_wdata;
  endtask
endmodule // flea_host

/* verification/test_flea_top.sv */
// Purpose: Self-checking bench for the fault log and storage block
// Assumes: Status clear delay shortened to 16 cycles
// Notes: Storage pointer is seen only through erased words
`timescale 1ns/100ps
module test_flea_top;
  logic mclk = 1'b0; // Clock
  logic rst_b = 1'b0; // Reset, low
  logic cmd_wr, cmd_rd, cmd_ack, cmd_nack, ee_enabled; // Command port
  logic [7:0] cmd_code, src_code, log_rdata; // Codes
  logic [15:0] cmd_wdata, cmd_rdata; // Words
  logic [7:0] die_temp = 8'd25; // Cool die
  logic log_wr = 1'b0; // Log write
  logic [7:0] log_addr = 8'h00, log_wdata = 8'h00, log_raddr = 8'h00; // Log port
  logic fault_ev = 1'b0, fault_ch = 1'b0, manual_save = 1'b0; // Events
  logic [3:0] fault_kind = 4'h0; // Fault kind
  logic [1:0] vstat_bit3; // Status bits
  int n_fail = 0; // Mismatches
  int samples_checked = 0; // Comparisons
  always #12.5 mclk = ~mclk;
  flea_top #(.STAT_CLR_CYC(16)) flea_top_i (.*);
  flea_host flea_host_i (.*);
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task pause(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Transfer, then judge the ack and nack pair
  task op(input logic rd, input logic [7:0] c, input logic [15:0] d, input logic [1:0] want);
    flea_host_i.xfer(rd, c, d);
    chk({cmd_ack, cmd_nack}, want);
  endtask
  task t_lock;
    op(1'b0, 8'hbe, 16'h0000, 2'b01);
    op(1'b0, 8'hbf, 16'h1234, 2'b01);
  endtask
  task t_store;
    op(1'b0, 8'hbd, 16'h002b, 2'b10);
    op(1'b1, 8'hbd, 16'h0000, 2'b10);
    chk(cmd_rdata, 16'h0001);
    op(1'b0, 8'hbe, 16'h0000, 2'b10);
    op(1'b0, 8'hbf, 16'h5a5a, 2'b01);
    pause(70);
    op(1'b0, 8'hbf, 16'h5a5a, 2'b10);
    op(1'b0, 8'hbf, 16'ha5a5, 2'b10);
    pause(8);
    op(1'b1, 8'hbf, 16'h0000, 2'b10);
    chk(cmd_rdata, 16'hffff);
    // Any other unlock value locks storage again
    op(1'b0, 8'hbd, 16'h0000, 2'b10);
    op(1'b0, 8'hbe, 16'h0000, 2'b01);
  endtask
  task t_hot;
    die_temp = 8'd131;
    pause(6);
    chk(ee_enabled, 1'b0);
    op(1'b0, 8'hbd, 16'h002b, 2'b01);
    die_temp = 8'd127;
    pause(6);
    chk(ee_enabled, 1'b0);
    die_temp = 8'd124;
    pause(6);
    chk(ee_enabled, 1'b1);
  endtask
  task automatic t_log;
    logic [3:0] kinds[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'ha};
    log_wr = 1'b1;
    log_addr = 8'd127;
    log_wdata = 8'h3c;
    pause(1);
    log_addr = 8'd146;
    log_wdata = 8'hc3;
    pause(1);
    log_wr = 1'b0;
    log_raddr = 8'd127;
    pause(2);
    chk(log_rdata, 8'h3c);
    log_raddr = 8'd146;
    pause(2);
    chk(log_rdata, 8'hc3);
    for (int i = 0; i < 16; i++) begin
      fault_ev = 1'b1;
      fault_ch = i[3];
      fault_kind = kinds[i[2:0]];
      pause(1);
      fault_ev = 1'b0;
      pause(1);
      chk(src_code, {3'b000, i[3], kinds[i[2:0]]});
    end
    manual_save = 1'b1;
    pause(1);
    manual_save = 1'b0;
    pause(1);
    chk(src_code, 8'hff);
    chk(vstat_bit3, 2'b11);
    op(1'b1, 8'hee, 16'h0000, 2'b01);
    op(1'b0, 8'hee, 16'h0000, 2'b10);
    pause(18);
    chk(vstat_bit3, 2'b00);
    pause(150);
    chk(log_rdata, 8'h00);
  endtask
  task wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    pause(20);
    rst_b = 1'b1;
    t_lock;
    t_store;
    t_hot;
    t_log;
    wrap_up;
  end
  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    repeat (3000) @(posedge mclk);
    n_fail++;
    wrap_up;
  end
endmodule // test_flea_top
